// *** rtl/itcf_pkg.sv ***
// Purpose: shared constants and carrier types for the interrupt trap/flag register block
// Assumes: one 50 MHz clock, APB register access, 16-bit registers in the low word lanes
// Notes: register offsets are byte addresses of aligned 32-bit words
package itcf_pkg;

  localparam int unsigned ITCF_ADDR_W = 12;
  localparam int unsigned ITCF_REG_W = 16;

  // register byte offsets
  localparam logic [11:0] ITCF_OFF_CTRL_ONE = 12'h000;
  localparam logic [11:0] ITCF_OFF_CTRL_TWO = 12'h004;
  localparam logic [11:0] ITCF_OFF_FLAGS_ZERO = 12'h008;
  localparam logic [11:0] ITCF_OFF_FLAGS_ONE = 12'h00c;

  localparam logic [15:0] ITCF_RESET_VAL = 16'h0000;

  // implemented (read-write) bit masks; every other bit reads zero except control two bit 14, the read-only timed disable
  localparam logic [15:0] ITCF_MASK_CTRL_ONE = 16'hffde;
  localparam logic [15:0] ITCF_MASK_CTRL_TWO_RW = 16'h8007;
  localparam logic [15:0] ITCF_MASK_FLAGS_ZERO = 16'h3fef;
  localparam logic [15:0] ITCF_MASK_FLAGS_ONE = 16'h20db;

  // interrupt_control_one fields
  localparam int unsigned ITCF_B_NESTING_DISABLE = 15;
  localparam int unsigned ITCF_B_ACC_A_OVF_FLAG = 14;
  localparam int unsigned ITCF_B_ACC_B_OVF_FLAG = 13;
  localparam int unsigned ITCF_B_ACC_A_CAT_FLAG = 12;
  localparam int unsigned ITCF_B_ACC_B_CAT_FLAG = 11;
  localparam int unsigned ITCF_B_ACC_A_OVF_EN = 10;
  localparam int unsigned ITCF_B_ACC_B_OVF_EN = 9;
  localparam int unsigned ITCF_B_CAT_EN = 8;
  localparam int unsigned ITCF_B_SHIFT_ERR = 7;
  localparam int unsigned ITCF_B_DIV_ZERO = 6;
  localparam int unsigned ITCF_B_MATH_TRAP = 4;
  localparam int unsigned ITCF_B_ADDR_TRAP = 3;
  localparam int unsigned ITCF_B_STACK_TRAP = 2;
  localparam int unsigned ITCF_B_OSC_TRAP = 1;

  // interrupt_control_two fields
  localparam int unsigned ITCF_B_ALT_VECTOR = 15;
  localparam int unsigned ITCF_B_TIMED_DISABLE = 14;
  localparam int unsigned ITCF_B_EXT0_POL = 0;
  localparam int unsigned ITCF_B_EXT1_POL = 1;
  localparam int unsigned ITCF_B_EXT2_POL = 2;

  // interrupt_flags_zero fields
  localparam int unsigned ITCF_B_ADC_DONE = 13;
  localparam int unsigned ITCF_B_UART_TX = 12;
  localparam int unsigned ITCF_B_UART_RX = 11;
  localparam int unsigned ITCF_B_SPI_EVENT = 10;
  localparam int unsigned ITCF_B_SPI_FAULT = 9;
  localparam int unsigned ITCF_B_TIMER3 = 8;
  localparam int unsigned ITCF_B_TIMER2 = 7;
  localparam int unsigned ITCF_B_COMPARE2 = 6;
  localparam int unsigned ITCF_B_CAPTURE2 = 5;
  localparam int unsigned ITCF_B_TIMER1 = 3;
  localparam int unsigned ITCF_B_COMPARE1 = 2;
  localparam int unsigned ITCF_B_CAPTURE1 = 1;
  localparam int unsigned ITCF_B_EXT_IRQ0 = 0;

  // interrupt_flags_one fields
  localparam int unsigned ITCF_B_EXT_IRQ2 = 13;
  localparam int unsigned ITCF_B_CAPTURE8 = 7;
  localparam int unsigned ITCF_B_CAPTURE7 = 6;
  localparam int unsigned ITCF_B_EXT_IRQ1 = 4;
  localparam int unsigned ITCF_B_CHANGE_NOTIFY = 3;
  localparam int unsigned ITCF_B_I2C_MASTER = 1;
  localparam int unsigned ITCF_B_I2C_SLAVE = 0;

  // trap events reported by the core, one-cycle pulses
  typedef struct packed {
    logic acc_a_overflow;
    logic acc_b_overflow;
    logic acc_a_catastrophic;
    logic acc_b_catastrophic;
    logic shift_error;
    logic divide_by_zero;
    logic address_error;
    logic stack_error;
    logic osc_failure;
  } itcf_trap_ev_t;

  // peripheral request events, one-cycle pulses
  typedef struct packed {
    logic adc_done;
    logic uart_tx;
    logic uart_rx;
    logic spi_event;
    logic spi_fault;
    logic timer3;
    logic timer2;
    logic compare2;
    logic capture2;
    logic timer1;
    logic compare1;
    logic capture1;
    logic capture8;
    logic capture7;
    logic change_notify;
    logic i2c_master;
    logic i2c_slave;
  } itcf_src_ev_t;

  // trap requests raised toward the core, one-cycle pulses
  typedef struct packed {
    logic math;
    logic address;
    logic stack;
    logic osc;
  } itcf_trap_req_t;

  // control levels presented to the core and priority logic
  typedef struct packed {
    logic nesting_disable;
    logic cpu_priority_level_write_enable;
    logic alternate_vector_select;
    logic acc_a_overflow_trap_enable;
    logic acc_b_overflow_trap_enable;
    logic catastrophic_trap_enable;
  } itcf_ctl_t;

endpackage

// *** rtl/itcf_top.sv ***
// Purpose: interrupt control/status and first two request flag registers behind APB
// Assumes: all inputs synchronous to pclk; event inputs are one-cycle pulses
// Notes: reads carry zero wait states; writes use pwdata[15:0], upper lanes ignored
//
// Contract
// RULE1 - control one bit 15 disables interrupt nesting when set
// RULE2 - set accumulator A/B overflow flags, bits 14/13, when that overflow traps
// RULE3 - set accumulator A/B catastrophic flags, bits 12/11, when that overflow traps
// RULE4 - accumulator A/B overflow traps only while bits 10/9 are set
// RULE5 - catastrophic overflow of either accumulator traps only while bit 8 is set
// RULE6 - bit 7 set when a math trap comes from an invalid accumulator shift
// RULE7 - bit 6 set when a math trap comes from a divide by zero
// RULE8 - bit 4 set whenever a math error trap occurs
// RULE9 - bit 3 set whenever an address error trap occurs
// RULE10 - bit 2 set whenever a stack error trap occurs
// RULE11 - bit 1 set whenever an oscillator failure trap occurs
// RULE12 - every unimplemented bit reads as zero
// RULE13 - control two bit 15 selects the alternate vector table
// RULE14 - control two read-only bit 14 shows an active timed interrupt disable
// RULE15 - external irq 0/1/2 edge chosen by bits 0/1/2: 1 falling, 0 rising
// RULE16 - flags zero: adc 13, uart tx 12, rx 11, spi 10, fault 9, t3 8, t2 7
// RULE17 - flags zero: compare2 6, capture2 5, timer1 3, compare1 2, capture1 1, ext0 0
// RULE18 - flags one: ext2 13, capture8 7, capture7 6, ext1 4, change 3, i2c 1/0
// RULE19 - sources set request flags; hardware never clears them, software does
// RULE20 - while nesting is disabled the cpu priority level bits are read-only
// RULE21 - all implemented bits reset to zero; writes visible the next cycle
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module itcf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire itcf_pkg::itcf_trap_ev_t trap_ev,
  input wire itcf_pkg::itcf_src_ev_t src_ev,
  input wire logic [2:0] ext_irq_pin,
  input wire logic timed_disable_active,
  output itcf_pkg::itcf_trap_req_t trap_req,
  output itcf_pkg::itcf_ctl_t ctl,
  output logic [2:0] ext_irq_edge_polarity,
  output logic [15:0] flags_zero,
  output logic [15:0] flags_one
);

  typedef struct packed {
    logic [15:0] ctrl_one;
    logic [15:0] ctrl_two;
    logic [15:0] flags_zero;
    logic [15:0] flags_one;
    logic [2:0] ext_prev;
    logic timed_disable;
    itcf_pkg::itcf_trap_req_t trap_req;
    itcf_pkg::itcf_ctl_t ctl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } itcf_state_t;

  itcf_state_t state_q;
  itcf_state_t state_d;

  // software write merge: implemented bits take the written value, then hardware sets win
  function automatic logic [15:0] itcf_merge(
    input logic [15:0] cur,
    input logic [15:0] wdata,
    input logic [15:0] mask,
    input logic wr,
    input logic [15:0] hw_set
  );
    logic [15:0] nxt;
    nxt = wr ? (wdata & mask) : cur;
    return (nxt | hw_set) & mask;
  endfunction

  // edge detect for a synchronous pin; polarity 1 means falling edge
  function automatic logic itcf_edge(
    input logic prev,
    input logic cur,
    input logic falling
  );
    return falling ? (prev & ~cur) : (~prev & cur);
  endfunction

  function automatic logic itcf_is_mapped(input logic [11:0] addr);
    return (addr == itcf_pkg::ITCF_OFF_CTRL_ONE) || (addr == itcf_pkg::ITCF_OFF_CTRL_TWO) ||
      (addr == itcf_pkg::ITCF_OFF_FLAGS_ZERO) || (addr == itcf_pkg::ITCF_OFF_FLAGS_ONE);
  endfunction

  logic setup_phase;
  logic access_done;
  logic wr_one;
  logic wr_two;
  logic wr_fz;
  logic wr_fo;
  logic [15:0] rd_word;
  logic [15:0] set_one;
  logic [15:0] set_fz;
  logic [15:0] set_fo;
  logic [2:0] ext_hit;
  logic [2:0] pol;
  logic acc_a_trap;
  logic acc_b_trap;
  logic cat_a_trap;
  logic cat_b_trap;
  logic math_trap;

  always_comb begin
    state_d = state_q;

    setup_phase = psel & ~penable;
    // a write lands only on the access edge where our pready is already high
    access_done = psel & penable & state_q.pready & pwrite & ~state_q.pslverr;
    wr_one = access_done && (paddr == itcf_pkg::ITCF_OFF_CTRL_ONE);
    wr_two = access_done && (paddr == itcf_pkg::ITCF_OFF_CTRL_TWO);
    wr_fz = access_done && (paddr == itcf_pkg::ITCF_OFF_FLAGS_ZERO);
    wr_fo = access_done && (paddr == itcf_pkg::ITCF_OFF_FLAGS_ONE);

    // trap qualification by the enables held in control one
    acc_a_trap = trap_ev.acc_a_overflow & state_q.ctrl_one[itcf_pkg::ITCF_B_ACC_A_OVF_EN]; // [RULE4]
    acc_b_trap = trap_ev.acc_b_overflow & state_q.ctrl_one[itcf_pkg::ITCF_B_ACC_B_OVF_EN]; // [RULE4]
    cat_a_trap = trap_ev.acc_a_catastrophic & state_q.ctrl_one[itcf_pkg::ITCF_B_CAT_EN]; // [RULE5]
    cat_b_trap = trap_ev.acc_b_catastrophic & state_q.ctrl_one[itcf_pkg::ITCF_B_CAT_EN]; // [RULE5]
    math_trap = acc_a_trap | acc_b_trap | cat_a_trap | cat_b_trap |
      trap_ev.shift_error | trap_ev.divide_by_zero;

    set_one = itcf_pkg::ITCF_RESET_VAL;
    set_one[itcf_pkg::ITCF_B_ACC_A_OVF_FLAG] = acc_a_trap; // [RULE2]
    set_one[itcf_pkg::ITCF_B_ACC_B_OVF_FLAG] = acc_b_trap; // [RULE2]
    set_one[itcf_pkg::ITCF_B_ACC_A_CAT_FLAG] = cat_a_trap; // [RULE3]
    set_one[itcf_pkg::ITCF_B_ACC_B_CAT_FLAG] = cat_b_trap; // [RULE3]
    set_one[itcf_pkg::ITCF_B_SHIFT_ERR] = trap_ev.shift_error; // [RULE6]
    set_one[itcf_pkg::ITCF_B_DIV_ZERO] = trap_ev.divide_by_zero; // [RULE7]
    set_one[itcf_pkg::ITCF_B_MATH_TRAP] = math_trap; // [RULE8]
    set_one[itcf_pkg::ITCF_B_ADDR_TRAP] = trap_ev.address_error; // [RULE9]
    set_one[itcf_pkg::ITCF_B_STACK_TRAP] = trap_ev.stack_error; // [RULE10]
    set_one[itcf_pkg::ITCF_B_OSC_TRAP] = trap_ev.osc_failure; // [RULE11]

    pol[0] = state_q.ctrl_two[itcf_pkg::ITCF_B_EXT0_POL];
    pol[1] = state_q.ctrl_two[itcf_pkg::ITCF_B_EXT1_POL];
    pol[2] = state_q.ctrl_two[itcf_pkg::ITCF_B_EXT2_POL];
    for (int i = 0; i < 3; i++) begin
      ext_hit[i] = itcf_edge(state_q.ext_prev[i], ext_irq_pin[i], pol[i]); // [RULE15]
    end

    set_fz = itcf_pkg::ITCF_RESET_VAL;
    set_fz[itcf_pkg::ITCF_B_ADC_DONE] = src_ev.adc_done; // [RULE16]
    set_fz[itcf_pkg::ITCF_B_UART_TX] = src_ev.uart_tx; // [RULE16]
    set_fz[itcf_pkg::ITCF_B_UART_RX] = src_ev.uart_rx; // [RULE16]
    set_fz[itcf_pkg::ITCF_B_SPI_EVENT] = src_ev.spi_event; // [RULE16]
    set_fz[itcf_pkg::ITCF_B_SPI_FAULT] = src_ev.spi_fault; // [RULE16]
    set_fz[itcf_pkg::ITCF_B_TIMER3] = src_ev.timer3; // [RULE16]
    set_fz[itcf_pkg::ITCF_B_TIMER2] = src_ev.timer2; // [RULE16]
    set_fz[itcf_pkg::ITCF_B_COMPARE2] = src_ev.compare2; // [RULE17]
    set_fz[itcf_pkg::ITCF_B_CAPTURE2] = src_ev.capture2; // [RULE17]
    set_fz[itcf_pkg::ITCF_B_TIMER1] = src_ev.timer1; // [RULE17]
    set_fz[itcf_pkg::ITCF_B_COMPARE1] = src_ev.compare1; // [RULE17]
    set_fz[itcf_pkg::ITCF_B_CAPTURE1] = src_ev.capture1; // [RULE17]
    set_fz[itcf_pkg::ITCF_B_EXT_IRQ0] = ext_hit[0]; // [RULE17]

    set_fo = itcf_pkg::ITCF_RESET_VAL;
    set_fo[itcf_pkg::ITCF_B_EXT_IRQ2] = ext_hit[2]; // [RULE18]
    set_fo[itcf_pkg::ITCF_B_CAPTURE8] = src_ev.capture8; // [RULE18]
    set_fo[itcf_pkg::ITCF_B_CAPTURE7] = src_ev.capture7; // [RULE18]
    set_fo[itcf_pkg::ITCF_B_EXT_IRQ1] = ext_hit[1]; // [RULE18]
    set_fo[itcf_pkg::ITCF_B_CHANGE_NOTIFY] = src_ev.change_notify; // [RULE18]
    set_fo[itcf_pkg::ITCF_B_I2C_MASTER] = src_ev.i2c_master; // [RULE18]
    set_fo[itcf_pkg::ITCF_B_I2C_SLAVE] = src_ev.i2c_slave; // [RULE18]

    // set beats a clearing write in the same cycle, so no request is lost
    state_d.ctrl_one = itcf_merge(state_q.ctrl_one, pwdata[15:0],
      itcf_pkg::ITCF_MASK_CTRL_ONE, wr_one, set_one); // [RULE21]
    state_d.ctrl_two = itcf_merge(state_q.ctrl_two, pwdata[15:0],
      itcf_pkg::ITCF_MASK_CTRL_TWO_RW, wr_two, itcf_pkg::ITCF_RESET_VAL); // [RULE12]
    state_d.flags_zero = itcf_merge(state_q.flags_zero, pwdata[15:0],
      itcf_pkg::ITCF_MASK_FLAGS_ZERO, wr_fz, set_fz); // [RULE19]
    state_d.flags_one = itcf_merge(state_q.flags_one, pwdata[15:0],
      itcf_pkg::ITCF_MASK_FLAGS_ONE, wr_fo, set_fo); // [RULE19]

    state_d.ext_prev = ext_irq_pin;
    state_d.timed_disable = timed_disable_active; // [RULE14]

    state_d.trap_req.math = math_trap;
    state_d.trap_req.address = trap_ev.address_error;
    state_d.trap_req.stack = trap_ev.stack_error;
    state_d.trap_req.osc = trap_ev.osc_failure;

    // controls follow the register value about to be stored
    state_d.ctl.nesting_disable = state_d.ctrl_one[itcf_pkg::ITCF_B_NESTING_DISABLE]; // [RULE1]
    state_d.ctl.cpu_priority_level_write_enable =
      ~state_d.ctrl_one[itcf_pkg::ITCF_B_NESTING_DISABLE]; // [RULE20]
    state_d.ctl.alternate_vector_select =
      state_d.ctrl_two[itcf_pkg::ITCF_B_ALT_VECTOR]; // [RULE13]
    state_d.ctl.acc_a_overflow_trap_enable = state_d.ctrl_one[itcf_pkg::ITCF_B_ACC_A_OVF_EN];
    state_d.ctl.acc_b_overflow_trap_enable = state_d.ctrl_one[itcf_pkg::ITCF_B_ACC_B_OVF_EN];
    state_d.ctl.catastrophic_trap_enable = state_d.ctrl_one[itcf_pkg::ITCF_B_CAT_EN];

    // read data is captured at the setup edge so pready can rise with it
    rd_word = itcf_pkg::ITCF_RESET_VAL;
    unique case (paddr)
      itcf_pkg::ITCF_OFF_CTRL_ONE: begin
        rd_word = state_q.ctrl_one & itcf_pkg::ITCF_MASK_CTRL_ONE; // [RULE12]
      end
      itcf_pkg::ITCF_OFF_CTRL_TWO: begin
        rd_word = state_q.ctrl_two & itcf_pkg::ITCF_MASK_CTRL_TWO_RW; // [RULE12]
        rd_word[itcf_pkg::ITCF_B_TIMED_DISABLE] = state_q.timed_disable; // [RULE14]
      end
      itcf_pkg::ITCF_OFF_FLAGS_ZERO: begin
        rd_word = state_q.flags_zero & itcf_pkg::ITCF_MASK_FLAGS_ZERO;
      end
      itcf_pkg::ITCF_OFF_FLAGS_ONE: begin
        rd_word = state_q.flags_one & itcf_pkg::ITCF_MASK_FLAGS_ONE;
      end
      default: begin
        rd_word = itcf_pkg::ITCF_RESET_VAL;
      end
    endcase

    if (setup_phase) begin
      state_d.pready = 1'b1;
      state_d.pslverr = ~itcf_is_mapped(paddr);
      state_d.prdata = (pwrite || !itcf_is_mapped(paddr)) ? 32'h0000_0000 : {16'h0000, rd_word};
    end else begin
      state_d.pready = 1'b0;
      state_d.pslverr = 1'b0;
      state_d.prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0; // [RULE21]
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.prdata;
  assign pready = state_q.pready;
  assign pslverr = state_q.pslverr;
  assign trap_req = state_q.trap_req;
  assign ctl = state_q.ctl;
  assign ext_irq_edge_polarity = state_q.ctrl_two[2:0];
  assign flags_zero = state_q.flags_zero;
  assign flags_one = state_q.flags_one;

endmodule

// *** testbench/itcf_src_model.sv ***
// Purpose: core and peripheral side, raising one event pulse on command
// Assumes: events are synchronous one-cycle pulses
// Notes: sel indexes {trap_ev, src_ev}, src_ev in the low 17 bits
`timescale 1ns/1ps
module itcf_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [4:0] sel,
  output itcf_pkg::itcf_trap_ev_t trap_ev,
  output itcf_pkg::itcf_src_ev_t src_ev
);
  logic [25:0] ev_q;
  // a source only ever sets; clearing is left to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ev_q <= 26'h0;
    else
      ev_q <= fire ? (26'h1 << sel) : 26'h0;
  end
  assign {trap_ev, src_ev} = ev_q;
endmodule

// *** testbench/itcf_asserts.sv ***
// Purpose: port timing checks for the register block
// Assumes: one pclk domain, presetn async active low
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
module itcf_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire itcf_pkg::itcf_trap_ev_t trap_ev,
  input wire itcf_pkg::itcf_src_ev_t src_ev,
  input wire logic [2:0] ext_irq_pin,
  input wire itcf_pkg::itcf_trap_req_t trap_req,
  input wire itcf_pkg::itcf_ctl_t ctl,
  input wire logic [2:0] ext_irq_edge_polarity,
  input wire logic [15:0] flags_zero,
  input wire logic [15:0] flags_one
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle");
  property p_unmap;
    pready && paddr > 12'h00c |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access");
  property p_upper;
    (flags_zero & ~itcf_pkg::ITCF_MASK_FLAGS_ZERO) == 16'h0
      && (flags_one & ~itcf_pkg::ITCF_MASK_FLAGS_ONE) == 16'h0 && prdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("unimplemented bit set");
  property p_t1;
    src_ev.timer1 |=> flags_zero[3];
  endproperty
  a_t1: assert property (p_t1) else $error("timer1 flag late");
  property p_sticky;
    flags_zero[3] && !(psel && penable && pwrite && paddr == 12'h008) |=> flags_zero[3];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_div;
    trap_ev.divide_by_zero |=> trap_req.math;
  endproperty
  a_div: assert property (p_div) else $error("no math trap");
  property p_addr;
    trap_ev.address_error |=> trap_req.address && !trap_req.osc;
  endproperty
  a_addr: assert property (p_addr) else $error("no address trap");
  property p_stack;
    trap_ev.stack_error |=> trap_req.stack;
  endproperty
  a_stack: assert property (p_stack) else $error("no stack trap");
  property p_osc;
    trap_ev.osc_failure |=> trap_req.osc;
  endproperty
  a_osc: assert property (p_osc) else $error("no oscillator trap");
  property p_ovf;
    trap_ev.acc_a_overflow && ctl.acc_a_overflow_trap_enable |=> trap_req.math;
  endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow trap");
  // gated on sampled reset: the release edge itself still shows reset values next cycle
  property p_prio;
    presetn |=> ctl.cpu_priority_level_write_enable == !ctl.nesting_disable;
  endproperty
  a_prio: assert property (p_prio) else $error("priority lock wrong");
  property p_ext;
    $rose(ext_irq_pin[0]) && !ext_irq_edge_polarity[0] |=> flags_zero[0];
  endproperty
  a_ext: assert property (p_ext) else $error("ext0 edge missed");
endmodule
bind itcf_top itcf_asserts u_itcf_asserts (.*);

// *** testbench/interrupt_trap_control_flags_test.sv ***
// Purpose: register-level tests of the trap and flag block
// Assumes: zero-wait APB slave, events from the source model
// Notes: expected values come from the bit tables, not the design
`timescale 1ns/1ps
module interrupt_trap_control_flags_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, tda = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, err_q;
  logic [4:0] sel = 5'h0;
  logic [2:0] pins = 3'h0, pol;
  logic [15:0] fz, fo;
  itcf_pkg::itcf_trap_ev_t trap_ev;
  itcf_pkg::itcf_src_ev_t src_ev;
  itcf_pkg::itcf_trap_req_t trap_req;
  itcf_pkg::itcf_ctl_t ctl;
  int num_errors = 0, checks_done = 0, cyc = 0;
  logic [11:0] offs [4] = '{12'h000, 12'h004, 12'h008, 12'h00c};
  logic [15:0] masks [4] = '{16'hffde, 16'h8007, 16'h3fef, 16'h20db};
  always #10 pclk = ~pclk;
  itcf_top u_itcf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trap_ev(trap_ev), .src_ev(src_ev), .ext_irq_pin(pins),
    .timed_disable_active(tda), .trap_req(trap_req), .ctl(ctl),
    .ext_irq_edge_polarity(pol), .flags_zero(fz), .flags_one(fo));
  itcf_src_model u_itcf_src_model (.pclk(pclk), .presetn(presetn), .fire(fire), .sel(sel),
    .trap_ev(trap_ev), .src_ev(src_ev));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // idle edge first so release and next setup never land in one step
  // the request stands until pready is seen at a rising edge; only the bench timeout ends a wait
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 16'h0000);
    chk($sformatf("reg %h", a), e, rd_q);
  endtask
  task automatic fire_ev(input logic [4:0] s);
    @(posedge pclk);
    fire <= 1'b1;
    sel <= s;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic set_pins(input logic [2:0] v);
    @(posedge pclk);
    pins <= v;
    repeat (3) @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0);
    foreach (offs[i]) xfer(1'b1, offs[i], 16'hffff);
    chk("nesting", 1'b1, ctl.nesting_disable);
    chk("prio_we", 1'b0, ctl.cpu_priority_level_write_enable);
    chk("alt_vec", 1'b1, ctl.alternate_vector_select);
    chk("polarity", 3'h7, pol);
    foreach (offs[i]) rd(offs[i], masks[i]);
    foreach (offs[i]) xfer(1'b1, offs[i], 16'h0000);
    foreach (offs[i]) rd(offs[i], 32'h0);
    rd(12'h010, 32'h0);
    chk("slverr", 1'b1, err_q);
    $display("test access done");
    for (int i = 0; i < 17; i++) fire_ev(5'(i));
    set_pins(3'h7);
    repeat (20) @(posedge pclk);
    chk("fz", 16'h3fef, fz);
    chk("fo", 16'h20db, fo);
    rd(12'h008, 16'h3fef);
    rd(12'h00c, 16'h20db);
    xfer(1'b1, 12'h004, 16'h0007);
    xfer(1'b1, 12'h008, 16'h0000);
    xfer(1'b1, 12'h00c, 16'h0000);
    rd(12'h008, 32'h0);
    set_pins(3'h0);
    rd(12'h008, 16'h0001);
    rd(12'h00c, 16'h2010);
    xfer(1'b1, 12'h008, 16'h0000);
    xfer(1'b1, 12'h00c, 16'h0000);
    set_pins(3'h7);
    rd(12'h008, 32'h0);
    rd(12'h00c, 32'h0);
    $display("test flags done");
    for (int i = 22; i < 26; i++) fire_ev(5'(i));
    rd(12'h000, 32'h0);
    xfer(1'b1, 12'h000, 16'h0700);
    for (int i = 17; i < 26; i++) fire_ev(5'(i));
    rd(12'h000, 16'h7fde);
    chk("ovf_a_en", 1'b1, ctl.acc_a_overflow_trap_enable);
    chk("ovf_b_en", 1'b1, ctl.acc_b_overflow_trap_enable);
    chk("cat_en", 1'b1, ctl.catastrophic_trap_enable);
    tda <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(12'h004, 16'h4007);
    $display("test traps done");
    stop_test;
  end
endmodule
